// *** bench/cef_asserts.sv ***
// Purpose: Port-level checks of the flag register block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Flag reads are checked only while the fault state is steady.
`timescale 1ns/1ps
`default_nettype none
module cef_asserts
	import cef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [CEF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire cef_state_t fault_state,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_flags;
		rd_take ##0 s_axi_araddr == CEF_OFS_FLAGS && $stable(fault_state) && $past(aresetn);
	endsequence
	chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid)
		else $error("outputs busy after reset");
	chk_state_bits: assert property (rd_flags |=> s_axi_rdata[13:9] == $past(fault_state))
		else $error("state bits wrong");
	chk_any_warn: assert property (rd_flags |=> s_axi_rdata[8] == (s_axi_rdata[10] | s_axi_rdata[9]))
		else $error("warning summary wrong");
	chk_unused_zero: assert property (rd_flags |=> s_axi_rdata[31:14] == 18'h0 && !s_axi_rdata[4])
		else $error("unused bits not zero");
	chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	chk_unmapped_rd: assert property (rd_take ##0 s_axi_araddr != CEF_OFS_FLAGS && s_axi_araddr != CEF_OFS_MASK
		|=> s_axi_rresp == CEF_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
endmodule
`default_nettype wire

// *** bench/cef_node_model.sv ***
// Purpose: Stand-in for the error counters and bus paths feeding the flag block.
// Assumes: The bench asks for states and events one cycle ahead.
// Notes: An event request held for one cycle becomes a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module cef_node_model
	import cef_pkg::*;
(
	input wire logic aclk,
	input wire cef_state_t st_req,
	input wire cef_event_t ev_req,
	output var cef_state_t fault_state,
	output var cef_event_t event_strobes
);
	always_ff @(posedge aclk) begin
		fault_state <= st_req;
		event_strobes <= ev_req;
	end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the error-state and event-flag register.
// Assumes: One bus transfer at a time, so answers pop in issue order.
// Notes: Handshakes are sampled at the falling edge, which avoids edge races.
`timescale 1ns/1ps
`default_nettype none
module tb import cef_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h00017856;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ah, wh, dn;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	cef_state_t st_req = '0, fault_state;
	cef_event_t ev_req = '0, event_strobes;
	logic [7:0] fl = 8'h00;
	logic [33:0] exp_q[$];
	int fail_count = 0, n_tests = 0;
	always #4 aclk = ~aclk;
	cef_top i_dut (.*);
	cef_node_model i_node (.aclk, .st_req, .ev_req, .fault_state, .event_strobes);
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [33:0] fx();
		return {CEF_RESP_OKAY, 18'h0, st_req, st_req[1] | st_req[0], fl};
	endfunction
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] e);
		n_tests++;
		if (seen !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready) check("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			dn = s_axi_bvalid;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end while (!dn);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			dn = s_axi_rvalid;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
		end while (!dn);
		s_axi_rready <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CEF_OFS_FLAGS, fx());
		rd(CEF_OFS_MASK, {CEF_RESP_OKAY, 32'h0});
		rd(4'h8, {CEF_RESP_SLVERR, 32'h0});
		wr(4'hC, 32'hFFFFFFFF, CEF_RESP_SLVERR);
		for (int i = 0; i < 5; i++) begin
			st_req <= 5'h01 << i;
			repeat (3) @(posedge aclk);
			fl[5] = 1'b1;
			rd(CEF_OFS_FLAGS, fx());
			wr(CEF_OFS_FLAGS, 32'h0, CEF_RESP_OKAY);
			fl = 8'h00;
		end
		st_req <= '0;
		for (int j = 0; j < 6; j++) begin
			@(posedge aclk);
			ev_req <= 6'h01 << j;
			@(posedge aclk);
			ev_req <= '0;
		end
		repeat (3) @(posedge aclk);
		fl = 8'hCF;
		rd(CEF_OFS_FLAGS, fx());
		// A zero written without its byte strobe must leave every flag set.
		s_axi_wstrb <= 4'hE;
		wr(CEF_OFS_FLAGS, 32'h0, CEF_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(CEF_OFS_FLAGS, fx());
		@(negedge aclk);
		check("irq", irq, 1'b0);
		wr(CEF_OFS_MASK, 32'hFFFFFFFF, CEF_RESP_OKAY);
		rd(CEF_OFS_MASK, {CEF_RESP_OKAY, 32'h000000EF});
		@(negedge aclk);
		check("irq", irq, 1'b1);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr_next(seed);
			wr(CEF_OFS_FLAGS, seed, CEF_RESP_OKAY);
			fl = fl & seed[7:0];
			rd(CEF_OFS_FLAGS, fx());
		end
		wr(CEF_OFS_FLAGS, 32'h0, CEF_RESP_OKAY);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		check("irq", irq, 1'b0);
		// The strobe lands on the very edge at which the clearing write takes effect.
		fork
			wr(CEF_OFS_FLAGS, 32'h0, CEF_RESP_OKAY);
			begin
				@(posedge aclk);
				ev_req <= 6'h20;
				@(posedge aclk);
				ev_req <= '0;
			end
		join
		fl = 8'h80;
		rd(CEF_OFS_FLAGS, fx());
		// A second reset with a flag, the mask and the interrupt all set.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		fl = 8'h00;
		rd(CEF_OFS_FLAGS, fx());
		rd(CEF_OFS_MASK, {CEF_RESP_OKAY, 32'h0});
		@(negedge aclk);
		check("irq", irq, 1'b0);
		report_and_stop();
	end
endmodule
bind cef_top cef_asserts i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .fault_state, .irq);
`default_nettype wire

// *** inc/cef_pkg.sv ***
// Purpose: Shared constants and carrier types for the CAN error-state and event-flag block.
// Assumes: AXI4-Lite with 32-bit data; every register takes one aligned word.
// Notes: The flag register is 16 bits wide and sits in the low half of the word.
package cef_pkg;

	localparam int unsigned CEF_ADDR_W = 4;
	localparam logic [3:0] CEF_OFS_FLAGS = 4'h0;
	localparam logic [3:0] CEF_OFS_MASK = 4'h4;

	localparam int unsigned CEF_BIT_TX_BUS_OFF = 13;
	localparam int unsigned CEF_BIT_TX_PASSIVE = 12;
	localparam int unsigned CEF_BIT_RX_PASSIVE = 11;
	localparam int unsigned CEF_BIT_TX_WARN = 10;
	localparam int unsigned CEF_BIT_RX_WARN = 9;
	localparam int unsigned CEF_BIT_ANY_WARN = 8;
	localparam int unsigned CEF_BIT_INVALID = 7;
	localparam int unsigned CEF_BIT_WAKEUP = 6;
	localparam int unsigned CEF_BIT_ERROR = 5;
	localparam int unsigned CEF_BIT_FIFO_FULL = 3;
	localparam int unsigned CEF_BIT_RX_OVF = 2;
	localparam int unsigned CEF_BIT_RX_BUF = 1;
	localparam int unsigned CEF_BIT_TX_BUF = 0;

	// Writable event flag positions: bits 7..5 and 3..0, bit 4 unimplemented.
	localparam logic [7:0] CEF_EVENT_MASK = 8'hEF;
	localparam logic [15:0] CEF_FLAGS_RESET = 16'h0000;
	localparam logic [7:0] CEF_MASK_RESET = 8'h00;

	localparam logic [1:0] CEF_RESP_OKAY = 2'h0;
	localparam logic [1:0] CEF_RESP_SLVERR = 2'h2;

	// Fault-confinement state levels from the error counter logic.
	typedef struct packed {
		logic tx_bus_off_state;
		logic tx_bus_passive_state;
		logic rx_bus_passive_state;
		logic tx_error_warning_state;
		logic rx_error_warning_state;
	} cef_state_t;

	// One-cycle event strobes from the receive and transmit paths.
	typedef struct packed {
		logic invalid_message;
		logic wakeup_activity;
		logic fifo_almost_full;
		logic rx_buffer_overflow;
		logic rx_buffer_event;
		logic tx_buffer_event;
	} cef_event_t;

	function automatic logic [15:0] cef_state_bits(input cef_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[CEF_BIT_TX_BUS_OFF] = s.tx_bus_off_state;
		v[CEF_BIT_TX_PASSIVE] = s.tx_bus_passive_state;
		v[CEF_BIT_RX_PASSIVE] = s.rx_bus_passive_state;
		v[CEF_BIT_TX_WARN] = s.tx_error_warning_state;
		v[CEF_BIT_RX_WARN] = s.rx_error_warning_state;
		v[CEF_BIT_ANY_WARN] = s.tx_error_warning_state | s.rx_error_warning_state;
		return v;
	endfunction

endpackage

// *** rtl/cef_event_flags.sv ***
// Purpose: Sticky event flags, cleared by writing zero.
// Assumes: Strobes are one-cycle pulses on aclk.
// Notes: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`default_nettype none
module cef_event_flags
	import cef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire cef_event_t events,
	input wire logic error_request,
	input wire logic clr_en,
	input wire logic [7:0] clr_data,
	input wire logic [7:0] clr_strb,
	output logic [7:0] flags
);

	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] set_v;

	always_comb begin
		set_v = 8'h00;
		set_v[CEF_BIT_INVALID] = events.invalid_message;
		set_v[CEF_BIT_WAKEUP] = events.wakeup_activity;
		set_v[CEF_BIT_ERROR] = error_request;
		set_v[CEF_BIT_FIFO_FULL] = events.fifo_almost_full;
		set_v[CEF_BIT_RX_OVF] = events.rx_buffer_overflow;
		set_v[CEF_BIT_RX_BUF] = events.rx_buffer_event;
		set_v[CEF_BIT_TX_BUF] = events.tx_buffer_event;
		flags_nxt = flags_r;
		if (clr_en) begin
			flags_nxt = flags_r & ~(clr_strb & ~clr_data);
		end
		flags_nxt = (flags_nxt | set_v) & CEF_EVENT_MASK;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= CEF_FLAGS_RESET[7:0];
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;

endmodule
`default_nettype wire

// *** rtl/cef_state_track.sv ***
// Purpose: Registers the fault-confinement states and flags any rise of them.
// Assumes: State levels come from logic on aclk.
// Notes: A rise of any state bit is one error request.
`timescale 1ns/1ps
`default_nettype none
module cef_state_track
	import cef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire cef_state_t state_in,
	output logic [15:0] state_bits,
	output logic error_request
);

	logic [15:0] state_r;
	logic [15:0] state_nxt;

	always_comb begin
		state_nxt = cef_state_bits(state_in);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CEF_FLAGS_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state_bits = state_r;
	// Only a new state raises a request, so a steady passive state does not refire.
	assign error_request = |(state_nxt & ~state_r);

endmodule
`default_nettype wire

// *** rtl/cef_top.sv ***
// Purpose: CAN error-state and event-flag register with AXI4-Lite access.
// Assumes: State levels and event strobes are synchronous to aclk.
// Notes: Flags offset 0x0, interrupt mask offset 0x4.
//
// Summary of operation
// - Bit 13 reads high while the transmitter is bus off.
// - Bit 12 reads high while the transmitter is bus passive.
// - Bit 11 reads high while the receiver is bus passive.
// - Bit 10 reads high while the transmitter is in error warning.
// - Bit 9 reads high while the receiver is in error warning.
// - Bit 8 reads high while either side is in error warning.
// - The error flag at bit 5 sets when any state bit of 13..8 raises a request.
// - Event flags clear only on a written zero; a written one leaves them.
// - Bit 7 latches on an invalid message.
// - Bit 6 latches on bus wake-up activity.
// - Bit 3 latches on receive FIFO almost full.
// - Bit 2 latches on receive buffer overflow.
// - Bits 15..14 and 4 read zero and ignore writes.
// - Bit 1 latches on a receive buffer event.
// - Bit 0 latches on a transmit buffer event.
`timescale 1ns/1ps
`default_nettype none
module cef_top
	import cef_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CEF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [CEF_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire cef_state_t fault_state,
	input wire cef_event_t event_strobes,
	output logic irq
);

	logic aw_held_r;
	logic [CEF_ADDR_W-1:0] aw_addr_r;
	logic w_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_fire;
	logic [7:0] mask_r;
	logic [15:0] state_bits;
	logic error_request;
	logic [7:0] flags;
	logic flag_clr;
	logic [1:0] rresp_nxt;
	logic [31:0] rdata_nxt;

	// Address and data are captured independently, so either may come first.
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CEF_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_r == CEF_OFS_FLAGS || aw_addr_r == CEF_OFS_MASK) begin
				s_axi_bresp <= CEF_RESP_OKAY;
			end else begin
				s_axi_bresp <= CEF_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r <= CEF_MASK_RESET;
		end else if (wr_fire && aw_addr_r == CEF_OFS_MASK && w_strb_r[0]) begin
			mask_r <= w_data_r[7:0] & CEF_EVENT_MASK;
		end
	end

	// State bits are read-only; only the low byte carries clearable flags.
	assign flag_clr = wr_fire && aw_addr_r == CEF_OFS_FLAGS;

	cef_state_track u_state (
		.aclk(aclk),
		.aresetn(aresetn),
		.state_in(fault_state),
		.state_bits(state_bits),
		.error_request(error_request)
	);

	cef_event_flags u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.events(event_strobes),
		.error_request(error_request),
		.clr_en(flag_clr),
		.clr_data(w_data_r[7:0]),
		.clr_strb({8{w_strb_r[0]}}),
		.flags(flags)
	);

	always_comb begin
		rdata_nxt = 32'h00000000;
		rresp_nxt = CEF_RESP_OKAY;
		if (s_axi_araddr == CEF_OFS_FLAGS) begin
			rdata_nxt[15:0] = state_bits | {8'h00, flags};
		end else if (s_axi_araddr == CEF_OFS_MASK) begin
			rdata_nxt[7:0] = mask_r;
		end else begin
			rresp_nxt = CEF_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= CEF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Level output so a missed edge never loses an interrupt.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags & mask_r);
		end
	end

endmodule
`default_nettype wire
